// ### verilog/dac_write_params.svh
// constants for the two-wire write receiver of the quad converter
`ifndef DAC_WRITE_PARAMS_SVH
`define DAC_WRITE_PARAMS_SVH
`define ADDR_PREFIX 5'h13
`define ADDR_PREFIX_MSB 7
`define ADDR_PREFIX_LSB 3
`define ADDR_PIN_HI 2
`define ADDR_PIN_LO 1
`define ADDR_RW_BIT 0
`define CTL_EXT_HI 7
`define CTL_EXT_LO 6
`define CTL_LOAD_HI 5
`define CTL_LOAD_LO 4
`define CTL_CHSEL_HI 2
`define CTL_CHSEL_LO 1
`define CTL_PD_BIT 0
`define CTL_BCAST_SEL 2
`define MODE_BIT_HI 7
`define MODE_BIT_LO 6
`define LOAD_HOLD 2'h0
`define LOAD_ONE 2'h1
`define LOAD_ALL 2'h2
`define LOAD_BCAST 2'h3
`define BIT_LAST 3'h7
`define BIT_FIRST 3'h0
`define REG_RESET 10'h000
`endif

// ### verilog/dac_write_pkg.sv
// types shared by the write receiver
package dac_write_pkg;
    typedef struct packed {
        logic scl;
        logic sda;
    } bus_in_t;
    typedef struct packed {
        logic [1:0] power_mode;
        logic [7:0] data;
    } chan_word_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_CTRL = 3'b011,
        ST_HIGH = 3'b010,
        ST_LOW = 3'b110,
        ST_IGNORE = 3'b111
    } phase_t;
endpackage

// ### verilog/dac_write_receiver.sv
// two-wire write receiver with per-channel holding and output registers
`timescale 1ns/10ps
`include "dac_write_params.svh"
module dac_write_receiver #(
    parameter int CHANNELS = 4
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire dac_write_pkg::bus_in_t BUS_IN,
    input wire logic [1:0] ADDR_PINS,
    input wire logic [1:0] EXT_ADDR_PINS,
    output logic SDA_OUT,
    output logic SDA_OE,
    output logic [CHANNELS*10-1:0] HOLD_WORDS,
    output logic [CHANNELS*10-1:0] OUT_WORDS,
    output logic UPDATE_PULSE,
    output logic BUSY
);
    import dac_write_pkg::*;

    logic scl_d_reg;
    logic sda_d_reg;
    phase_t phase_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] high_reg;
    // ack slot: armed when a byte is taken, open for the whole ack clock
    logic ack_arm_reg;
    logic ack_reg;
    logic ack_is_low_reg;
    logic ctl_match;
    chan_word_t hold_reg [CHANNELS];
    chan_word_t out_reg [CHANNELS];

    // a byte takes eight scl clocks plus one ack clock; the ack clock must
    // never be shifted in as data, so the slot is tracked in two steps:
    // armed at the rise of bit 8, opened by the fall that ends bit 8 and
    // closed by the fall that ends the ack clock
    // sda is only pulled low while the slot is open, so the master sees the
    // ack level for the whole high time of the ack clock
    // the update fires on the fall that closes the slot after a low byte
    wire scl_rise = BUS_IN.scl && !scl_d_reg;
    wire scl_fall = !BUS_IN.scl && scl_d_reg;
    // start and stop are sda edges while scl stays high
    wire start_cond = BUS_IN.scl && scl_d_reg && sda_d_reg && !BUS_IN.sda;
    wire stop_cond = BUS_IN.scl && scl_d_reg && !sda_d_reg && BUS_IN.sda;
    wire [7:0] byte_in = {shift_reg[6:0], BUS_IN.sda};
    // a bit counts only outside the ack slot and while the address byte is coming in or this device is addressed
    wire bit_taken = scl_rise && !ack_reg && !ack_arm_reg
        && phase_reg != ST_IDLE && phase_reg != ST_IGNORE;
    wire byte_done = bit_taken && bit_cnt_reg == `BIT_LAST;
    wire addr_ok = byte_in[`ADDR_PREFIX_MSB:`ADDR_PREFIX_LSB] == `ADDR_PREFIX
        && byte_in[`ADDR_PIN_HI:`ADDR_PIN_LO] == ADDR_PINS
        && !byte_in[`ADDR_RW_BIT];
    // update happens as scl falls at the end of the low-byte ack
    wire upd_now = scl_fall && ack_reg && ack_is_low_reg;
    wire [1:0] load_sel = ctrl_reg[`CTL_LOAD_HI:`CTL_LOAD_LO];
    wire [1:0] chan_sel = ctrl_reg[`CTL_CHSEL_HI:`CTL_CHSEL_LO];
    wire pd_mode = ctrl_reg[`CTL_PD_BIT];

    // extended address bits must match except for broadcast
    always_comb begin
        ctl_match = ctrl_reg[`CTL_EXT_HI:`CTL_EXT_LO] == EXT_ADDR_PINS
            || load_sel == `LOAD_BCAST;
    end

    // bus edge history; inputs are already synchronous
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else if (CE) begin
            scl_d_reg <= BUS_IN.scl;
            sda_d_reg <= BUS_IN.sda;
        end
    end

    // byte framing and phase sequencing
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            phase_reg <= ST_IDLE;
            bit_cnt_reg <= `BIT_FIRST;
            shift_reg <= 8'h00;
            ctrl_reg <= 8'h00;
            high_reg <= 8'h00;
        end else if (CE) begin
            if (start_cond) begin
                // repeated start returns to addressing, a cut pair is dropped
                phase_reg <= ST_ADDR;
                bit_cnt_reg <= `BIT_FIRST;
            end else if (stop_cond) begin
                phase_reg <= ST_IDLE;
                bit_cnt_reg <= `BIT_FIRST;
            end else if (bit_taken) begin
                shift_reg <= byte_in;
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (byte_done) begin
                    unique case (phase_reg)
                        ST_ADDR: begin
                            // a foreign address or a read sits out the transfer
                            phase_reg <= addr_ok ? ST_CTRL : ST_IGNORE;
                        end
                        ST_CTRL: begin
                            ctrl_reg <= byte_in;
                            phase_reg <= ST_HIGH;
                        end
                        ST_HIGH: begin
                            high_reg <= byte_in;
                            phase_reg <= ST_LOW;
                        end
                        ST_LOW: begin
                            // power-down takes one pair, data repeats
                            phase_reg <= pd_mode ? ST_IGNORE : ST_HIGH;
                        end
                        default: begin
                            // unused codes fall back to sitting out
                            phase_reg <= ST_IGNORE;
                        end
                    endcase
                end
            end
        end
    end

    // ack slot tracking; low byte bits are ignored but still acked
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            ack_arm_reg <= 1'b0;
            ack_reg <= 1'b0;
            ack_is_low_reg <= 1'b0;
        end else if (CE) begin
            if (start_cond || stop_cond) begin
                // a start or stop inside an ack abandons it, no update
                ack_arm_reg <= 1'b0;
                ack_reg <= 1'b0;
                ack_is_low_reg <= 1'b0;
            end else if (byte_done) begin
                ack_arm_reg <= phase_reg != ST_ADDR || addr_ok;
                ack_is_low_reg <= phase_reg == ST_LOW;
            end else if (scl_fall && ack_arm_reg) begin
                // bit 8 has ended, the ack clock follows
                ack_arm_reg <= 1'b0;
                ack_reg <= 1'b1;
            end else if (scl_fall && ack_reg) begin
                // ack clock over; the next rise is the first bit again
                ack_reg <= 1'b0;
                ack_is_low_reg <= 1'b0;
            end
        end
    end

    // sda driver: pull low only for the ack clock, start and stop release it
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            SDA_OE <= 1'b0;
            SDA_OUT <= 1'b1;
        end else if (CE) begin
            SDA_OUT <= 1'b0;
            if (start_cond || stop_cond || (scl_fall && ack_reg)) begin
                SDA_OE <= 1'b0;
            end else if (scl_fall && ack_arm_reg) begin
                SDA_OE <= 1'b1;
            end
        end
    end

    // holding and output registers, one set per channel
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            wire sel_hit = chan_sel == 2'(ch);
            wire bcast_data = ctrl_reg[`CTL_BCAST_SEL];
            wire wr_hold = load_sel == `LOAD_BCAST ? bcast_data : (sel_hit && ctl_match);
            wire ld_out = load_sel == `LOAD_ALL || load_sel == `LOAD_BCAST
                || (load_sel == `LOAD_ONE && sel_hit);
            chan_word_t new_word;
            always_comb begin
                // power-down high byte: mode bits in 7:6, data kept
                new_word.power_mode = pd_mode ? high_reg[`MODE_BIT_HI:`MODE_BIT_LO] : 2'h0;
                new_word.data = pd_mode ? hold_reg[ch].data : high_reg;
            end
            always_ff @(posedge SYS_CLK) begin
                if (!RSTN) begin
                    hold_reg[ch] <= `REG_RESET;
                    out_reg[ch] <= `REG_RESET;
                end else if (CE && upd_now && ctl_match) begin
                    if (wr_hold) begin
                        hold_reg[ch] <= new_word;
                    end
                    if (ld_out) begin
                        // all-channel loads use stored words for others
                        out_reg[ch] <= wr_hold ? new_word : hold_reg[ch];
                    end
                end
            end
            assign HOLD_WORDS[ch*10 +: 10] = hold_reg[ch];
            assign OUT_WORDS[ch*10 +: 10] = out_reg[ch];
        end
    endgenerate

    // update strobe, registered on the same edge that ends the ack and loads the words
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            UPDATE_PULSE <= 1'b0;
        end else if (CE) begin
            UPDATE_PULSE <= upd_now && ctl_match;
        end
    end

    // busy stays up through the last ack, so a power-down pair that has
    // already moved to sitting out still reads as addressed until it lands
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            BUSY <= 1'b0;
        end else if (CE) begin
            BUSY <= (phase_reg != ST_IDLE && phase_reg != ST_IGNORE)
                || ack_arm_reg || ack_reg;
        end
    end
endmodule

// ### sim/dac_write_receiver_monitor.sv
// concurrent checks on the write receiver's ports
`timescale 1ns/10ps
module dac_write_receiver_monitor #(
    parameter int CHANNELS = 4
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire dac_write_pkg::bus_in_t BUS_IN,
    input wire logic [1:0] ADDR_PINS,
    input wire logic [1:0] EXT_ADDR_PINS,
    input wire logic SDA_OUT,
    input wire logic SDA_OE,
    input wire logic [CHANNELS*10-1:0] HOLD_WORDS,
    input wire logic [CHANNELS*10-1:0] OUT_WORDS,
    input wire logic UPDATE_PULSE,
    input wire logic BUSY
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    // ack timing is tied to the scl fall seen one clock earlier
    ack_start_a: assert property (
        $rose(SDA_OE) |-> $past(BUS_IN.scl, 2) && !$past(BUS_IN.scl))
        else $error("ack began off the scl fall");
    ack_end_a: assert property (
        $fell(SDA_OE) |-> $past(BUS_IN.scl, 2) && !$past(BUS_IN.scl))
        else $error("ack ended off the scl fall");
    ack_low_a: assert property (SDA_OE |-> !SDA_OUT)
        else $error("ack drives sda high");
    // only an addressed transfer may pull sda
    ack_busy_a: assert property (SDA_OE |-> BUSY)
        else $error("ack given while not addressed");
    // words move only with the update pulse, which closes an ack
    pulse_one_a: assert property (UPDATE_PULSE |=> !UPDATE_PULSE)
        else $error("update pulse longer than one clock");
    pulse_ack_a: assert property (UPDATE_PULSE |-> $fell(SDA_OE))
        else $error("update not at end of ack");
    pulse_busy_a: assert property (UPDATE_PULSE |-> $past(BUSY))
        else $error("update outside an addressed transfer");
    out_pulse_a: assert property (!$stable(OUT_WORDS) |-> UPDATE_PULSE)
        else $error("output words changed without update");
    hold_pulse_a: assert property (!$stable(HOLD_WORDS) |-> UPDATE_PULSE)
        else $error("holding words changed without update");
endmodule
bind dac_write_receiver dac_write_receiver_monitor #(.CHANNELS(CHANNELS)) mon (
    .SYS_CLK(SYS_CLK), .RSTN(RSTN), .CE(CE), .BUS_IN(BUS_IN), .ADDR_PINS(ADDR_PINS),
    .EXT_ADDR_PINS(EXT_ADDR_PINS), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .HOLD_WORDS(HOLD_WORDS), .OUT_WORDS(OUT_WORDS), .UPDATE_PULSE(UPDATE_PULSE), .BUSY(BUSY));

// ### sim/i2c_master_model.sv
// two-wire bus master model feeding the write receiver
`timescale 1ns/10ps
module i2c_master_model (
    input wire logic clk,
    input wire logic dev_oe,
    input wire logic dev_out,
    output dac_write_pkg::bus_in_t bus
);
    logic scl_drv = 1'b1;
    logic sda_drv = 1'b1;
    // pull-up: a released line reads high unless the device pulls it
    assign bus = '{scl: scl_drv, sda: sda_drv & (dev_oe ? dev_out : 1'b1)};
    // each phase is four clocks, far slower than the receiver's sampling
    task automatic half(input logic c, input logic d);
        @(negedge clk);
        scl_drv = c;
        sda_drv = d;
        repeat (3) @(negedge clk);
    endtask
    task automatic start(); // repeated start when called mid-transfer
        half(1'b0, 1'b1);
        half(1'b1, 1'b1);
        half(1'b1, 1'b0);
        half(1'b0, 1'b0);
    endtask
    task automatic stop();
        half(1'b0, 1'b0);
        half(1'b1, 1'b0);
        half(1'b1, 1'b1);
    endtask
    // sda only moves while scl is low; ack taken while scl is high
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin // msb first
            half(1'b0, b[i]);
            half(1'b1, b[i]);
            half(1'b0, b[i]);
        end
        half(1'b0, 1'b1);
        half(1'b1, 1'b1);
        ack = ~bus.sda;
        half(1'b0, 1'b1);
    endtask
endmodule

// ### sim/tb_dac_write_receiver.sv
// self-checking bench for the write receiver
`timescale 1ns/10ps
module tb_dac_write_receiver;
    import dac_write_pkg::*;
    localparam logic [1:0] PINS = 2'h1;
    localparam logic [1:0] EXT = 2'h2;
    localparam logic [7:0] ADDR = {5'h13, PINS, 1'b0};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    bus_in_t bus_in;
    logic sda_out, sda_oe, upd, busy;
    logic [39:0] hold, outw;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    int pulses = 0;
    dac_write_receiver #(.CHANNELS(4)) dut (.SYS_CLK(clk), .RSTN(rstn), .CE(1'b1),
        .BUS_IN(bus_in), .ADDR_PINS(PINS), .EXT_ADDR_PINS(EXT), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .HOLD_WORDS(hold), .OUT_WORDS(outw), .UPDATE_PULSE(upd), .BUSY(busy));
    i2c_master_model m (.clk(clk), .dev_oe(sda_oe), .dev_out(sda_out), .bus(bus_in));
    // update strobes counted on the falling clock edge, away from the launching edge
    always @(negedge clk) begin
        if (upd === 1'b1) begin
            pulses++;
        end
    end
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // n bytes after control: even ones are high bytes counting up, odd ones low bytes
    task automatic xfer(input logic [7:0] a, c, hi, input int n, input logic ack, input logic fin);
        logic k;
        m.start();
        m.put_byte(a, k);
        chk(40'(k), 40'(ack));
        chk(40'(busy), 40'(ack));
        if (ack) begin
            m.put_byte(c, k);
            chk(40'(k), 40'h1);
            for (int i = 0; i < n; i++) begin
                m.put_byte(i[0] ? 8'hff : hi + 8'(i / 2), k);
                chk(40'(k), 40'h1);
            end
        end
        if (fin) begin
            m.stop();
            chk(40'(busy), 40'h0);
        end
    endtask
    // words are {mode, data} per channel, channel n at bit 10n
    task automatic words(input logic [39:0] h, input logic [39:0] o, input string name);
        chk(hold, h);
        chk(outw, o);
        $display("test %s done", name);
    endtask
    task automatic t_data();
        xfer(ADDR, {EXT, 2'h1, 1'b0, 2'h2, 1'b0}, 8'ha5, 4, 1'b1, 1'b1);
        words(40'h0a6 << 20, 40'h0a6 << 20, "pairs");
        xfer(ADDR, {EXT, 2'h0, 1'b0, 2'h1, 1'b0}, 8'h5a, 2, 1'b1, 1'b0);
        words(40'h0a6 << 20 | 40'h05a << 10, 40'h0a6 << 20, "hold only");
        xfer(ADDR, {EXT, 2'h2, 1'b0, 2'h0, 1'b0}, 8'h11, 2, 1'b1, 1'b1);
        words(40'h0a6 << 20 | 40'h05a << 10 | 40'h011, 40'h0a6 << 20 | 40'h05a << 10 | 40'h011,
            "load all");
    endtask
    task automatic t_power();
        xfer(ADDR, {EXT, 2'h1, 1'b0, 2'h2, 1'b1}, 8'h80, 2, 1'b1, 1'b1);
        words(40'h2a6 << 20 | 40'h05a << 10 | 40'h011, 40'h2a6 << 20 | 40'h05a << 10 | 40'h011,
            "power down");
    endtask
    // refused address, read direction, foreign control, and a pair cut short
    task automatic t_refuse();
        xfer(ADDR ^ 8'h02, {EXT, 2'h1, 1'b0, 2'h3, 1'b0}, 8'h33, 2, 1'b0, 1'b1);
        xfer(ADDR | 8'h01, {EXT, 2'h1, 1'b0, 2'h3, 1'b0}, 8'h33, 2, 1'b0, 1'b1);
        xfer(ADDR, {~EXT, 2'h1, 1'b0, 2'h3, 1'b0}, 8'h33, 2, 1'b1, 1'b1);
        xfer(ADDR, {EXT, 2'h1, 1'b0, 2'h3, 1'b0}, 8'h44, 1, 1'b1, 1'b1);
        words(40'h2a6 << 20 | 40'h05a << 10 | 40'h011, 40'h2a6 << 20 | 40'h05a << 10 | 40'h011,
            "refusals");
    endtask
    task automatic t_bcast();
        xfer(ADDR, {~EXT, 2'h3, 1'b0, 2'h2, 1'b0}, 8'h77, 2, 1'b1, 1'b1);
        words(40'h1dc771dc77, 40'h1dc771dc77, "broadcast");
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        words(40'h0, 40'h0, "reset");
        t_data();
        t_power();
        t_refuse();
        t_bcast();
        // two data pairs, hold only, load all, power down, broadcast
        chk(40'(pulses), 40'h6);
        stop_test();
    end
endmodule
